// ### ddb_pkg.sv
// shared constants for the mode register and burst ordering block
package ddb_pkg;
    localparam int COL_W = 10;
    localparam int ADDR_W = 13;
    // column organisations
    localparam int ORG_X8 = 0;
    localparam int ORG_X16 = 1;
    localparam int ORG_X32 = 2;
    localparam logic [9:0] COL_MASK_X8 = 10'h3FF;
    localparam logic [9:0] COL_MASK_X16 = 10'h1FF;
    localparam logic [9:0] COL_MASK_X32 = 10'h2FF;
    // base mode register fields
    localparam int MR_BL_LSB = 0;
    localparam int MR_BT_BIT = 3;
    localparam int MR_CL_LSB = 4;
    localparam int MR_TM_BIT = 7;
    localparam int MR_DLLRST_BIT = 8;
    localparam logic [2:0] BL_CODE_2 = 3'h1;
    localparam logic [2:0] BL_CODE_4 = 3'h2;
    localparam logic [2:0] BL_CODE_8 = 3'h3;
    localparam logic [2:0] CL_CODE_2 = 3'h2;
    localparam logic [2:0] CL_CODE_3 = 3'h3;
    localparam logic [2:0] CL_CODE_25 = 3'h6;
    // extended mode register fields
    localparam int EMR_DLLDIS_BIT = 0;
    localparam int EMR_DS_BIT = 1;
    localparam logic [1:0] BA_MR = 2'h0;
    localparam logic [1:0] BA_EMR = 2'h1;
    localparam logic [6:0] MODE_RST = 7'h00;
    localparam logic [1:0] EXT_RST = 2'h0;
    localparam int DLL_LOCK_CYC = 200;
    // register word indices on the avalon bus
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_MODE = 3'h1;
    localparam logic [2:0] REG_EXT = 3'h2;
    localparam logic [2:0] REG_STATUS = 3'h3;
    localparam logic [2:0] REG_BURST = 3'h4;
    localparam logic CTRL_EN_RST = 1'b1;
    localparam int ST_DLL_EN = 0;
    localparam int ST_DLL_RDY = 1;
    localparam int ST_DS = 2;
    localparam int ST_RSVD = 3;
    localparam int ST_BUSY = 4;
    localparam int BR_RD_BIT = 16;
endpackage

// ### ddb_burst_if.sv
// carrier between the mode logic and the burst column sequencer
interface ddb_burst_if;
    logic start;
    logic [9:0] col;
    logic [2:0] bl_code;
    logic ilv;
    logic [9:0] col_out;
    logic col_valid;
    logic last;
    logic [2:0] mask;
    modport ctl (output start, col, bl_code, ilv, input col_out, col_valid, last, mask);
    modport seq (input start, col, bl_code, ilv, output col_out, col_valid, last, mask);
endinterface

// ### ddb_burst_seq.sv
// burst column sequencer: wrap within block, sequential or interleaved
module ddb_burst_seq
    import ddb_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_nrst,
    ddb_burst_if.seq bus
);
    typedef enum logic [1:0] {SEQ_IDLE = 2'b01, SEQ_RUN = 2'b10} ddb_seq_e;
    ddb_seq_e state_reg;
    logic [9:0] base_reg;
    logic [2:0] start_reg;
    logic [2:0] mask_reg;
    logic [2:0] cnt_reg;
    logic [9:0] col_reg;
    logic valid_reg;
    logic last_reg;
    logic [2:0] mask_next;

    function automatic logic [2:0] ddb_elem(input logic [2:0] s, input logic [2:0] k,
        input logic [2:0] m, input logic il);
        ddb_elem = il ? ((s ^ k) & m) : ((s + k) & m); // see RL5
    endfunction

    always_comb
    begin
        unique case (bus.bl_code)
            BL_CODE_4: mask_next = 3'h3; // see RL2
            BL_CODE_8: mask_next = 3'h7; // see RL3
            default: mask_next = 3'h1; // see RL1
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            state_reg <= SEQ_IDLE;
            base_reg <= 10'h000;
            start_reg <= 3'h0;
            mask_reg <= 3'h1;
            cnt_reg <= 3'h0;
            col_reg <= 10'h000;
            valid_reg <= 1'b0;
            last_reg <= 1'b0;
        end
        else if (bus.start)
        begin
            // a new command truncates any burst still running
            state_reg <= SEQ_RUN;
            base_reg <= bus.col & ~{7'h00, mask_next}; // see RL4
            start_reg <= bus.col[2:0] & mask_next;
            mask_reg <= mask_next;
            cnt_reg <= 3'h1;
            col_reg <= bus.col;
            valid_reg <= 1'b1;
            last_reg <= 1'b0;
        end
        else
        begin
            unique case (state_reg)
                SEQ_IDLE:
                begin
                    valid_reg <= 1'b0;
                    last_reg <= 1'b0;
                end
                SEQ_RUN:
                begin
                    col_reg <= base_reg | {7'h00, ddb_elem(start_reg, cnt_reg, mask_reg,
                        bus.ilv)}; // see RL4
                    cnt_reg <= cnt_reg + 3'h1;
                    last_reg <= (cnt_reg == mask_reg);
                    if (cnt_reg == mask_reg)
                        state_reg <= SEQ_IDLE;
                end
            endcase
        end
    end

    assign bus.col_out = col_reg;
    assign bus.col_valid = valid_reg;
    assign bus.last = last_reg;
    assign bus.mask = mask_reg;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    first_elem_a: assert property (bus.start |=> bus.col_out == $past(bus.col)) // see RL1
        else $error("first burst element is not the start column");
    block_wrap_a: assert property (bus.col_valid |-> // see RL4
        (bus.col_out & ~{7'h00, mask_reg}) == base_reg)
        else $error("burst left its column block");
    // the eighth element shows eight cycles after the start edge
    bl8_length_a: assert property ((bus.start && bus.bl_code == BL_CODE_8) // see RL3
        ##1 (!bus.start) [*8] |-> bus.last)
        else $error("eight element burst did not end on its eighth column");
endmodule // ddb_burst_seq

// ### ddb_mode_burst.sv
// mode register, extended mode register, read latency and burst order
// Operation
// RL1 - BL2: A0 starts, upper bits pick block
// RL2 - BL4: A1..A0 start, upper bits pick block
// RL3 - BL8: A2..A0 start, upper bits pick block
// RL4 - bursts wrap inside their block
// RL5 - sequential adds, interleaved xors offset
// RL6 - mode bit three picks burst type
// RL7 - top column bit nine, eight for x16
// RL8 - one burst length for reads, writes
// RL9 - first read data after latency minus one
// RL10 - normal mode: bits seven upward zero
// RL11 - bit eight alone high resets the dll
// RL12 - dll reset followed by normal mode set
// RL13 - other high address codes are reserved
// RL14 - bank code one loads extended register
// RL15 - extended load only when idle, then wait
// RL16 - controller keeps the dll enabled; an extended load with bit zero set still drops o_dll_enable here
// RL17 - self refresh exit enables the dll
// RL18 - dll enable needs reset, 200 cycles
// RL19 - extended register picks drive strength
// RL20 - bank code zero loads base register
// RL21 - base fields: length, type, latency, reset
// RL22 - lengths two, four, eight, both types
// RL23 - customary field codes, latency 2.5 too
module ddb_mode_burst
    import ddb_pkg::*;
#(
    parameter int ORG = ORG_X8,
    parameter int DLL_LOCK_CYCLES = DLL_LOCK_CYC
)
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [2:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_cmd_mrs,
    input wire logic i_cmd_read,
    input wire logic i_cmd_write,
    input wire logic [1:0] i_cmd_ba,
    input wire logic [ADDR_W-1:0] i_cmd_addr,
    input wire logic i_sr_exit,
    output logic [9:0] o_col_addr,
    output logic o_col_valid,
    output logic o_col_last,
    output logic o_col_is_read,
    output logic o_rd_first_valid,
    output logic o_rd_half_cycle,
    output logic o_dll_enable,
    output logic o_dll_reset,
    output logic o_dll_ready,
    output logic o_output_drive_select
);
    // x32 parts use bit eight for auto precharge, so it is not a column bit
    localparam logic [9:0] COL_MASK = (ORG == ORG_X16) ? COL_MASK_X16 :
        (ORG == ORG_X32) ? COL_MASK_X32 : COL_MASK_X8; // see RL7
    localparam int TOP_COLUMN_BIT = (ORG == ORG_X16) ? 8 : 9;

    ddb_burst_if bif ();

    logic ctrl_en_reg;
    logic [6:0] mode_reg;
    logic [1:0] ext_reg;
    logic rsvd_reg;
    logic dll_rst_reg;
    logic [15:0] lock_cnt_reg;
    logic [1:0] rd_pipe_reg;
    logic rd_first_reg;
    logic is_read_reg;
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic mrs_go;
    logic mr_normal;
    logic mr_dllrst;
    logic emr_go;
    logic col_go;
    logic rd_go;
    logic bl_ok;
    logic [1:0] cl_cyc;
    logic bus_req;
    logic bus_wr;
    logic [31:0] rd_mux;
    logic [31:0] status_word;

    // mode register and column commands are ignored while software holds the block disabled; self refresh exit still acts
    assign mrs_go = ctrl_en_reg && i_cmd_mrs;
    assign mr_normal = mrs_go && i_cmd_ba == BA_MR && i_cmd_addr[ADDR_W-1:MR_TM_BIT] == '0;
    assign mr_dllrst = mrs_go && i_cmd_ba == BA_MR && i_cmd_addr[MR_DLLRST_BIT]
        && !i_cmd_addr[MR_TM_BIT] && i_cmd_addr[ADDR_W-1:MR_DLLRST_BIT+1] == '0;
    assign emr_go = mrs_go && i_cmd_ba == BA_EMR; // see RL14
    assign bl_ok = mode_reg[2:0] == BL_CODE_2 || mode_reg[2:0] == BL_CODE_4
        || mode_reg[2:0] == BL_CODE_8; // see RL22
    assign col_go = ctrl_en_reg && bl_ok && !i_cmd_mrs && (i_cmd_read || i_cmd_write);
    assign rd_go = col_go && i_cmd_read;

    // base mode register: only normal and dll reset codes load it
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
            mode_reg <= MODE_RST;
        else if (mr_normal || mr_dllrst)
            mode_reg <= i_cmd_addr[6:0]; // see RL10 see RL11 see RL20 see RL21
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
            dll_rst_reg <= 1'b0;
        else
            dll_rst_reg <= mr_dllrst; // see RL11
    end

    // reserved codes are refused and flagged; set wins over the clear
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
            rsvd_reg <= 1'b0;
        else if (mrs_go && i_cmd_ba == BA_MR && !mr_normal && !mr_dllrst)
            rsvd_reg <= 1'b1; // see RL13
        else if (bus_wr && i_avs_address == REG_STATUS && i_avs_byteenable[0]
            && i_avs_writedata[ST_RSVD])
            rsvd_reg <= 1'b0;
    end

    // extended register keeps only dll disable and drive strength
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
            ext_reg <= EXT_RST;
        else
        begin
            if (emr_go)
                ext_reg <= i_cmd_addr[1:0]; // see RL14 see RL23
            if (i_sr_exit)
                ext_reg[EMR_DLLDIS_BIT] <= 1'b0; // see RL17
        end
    end

    // lock counter shows when the 200 cycles after a dll reset have run
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
            lock_cnt_reg <= 16'h0000;
        else if (mr_dllrst)
            lock_cnt_reg <= 16'h0000; // see RL18
        else if (lock_cnt_reg < 16'(DLL_LOCK_CYCLES))
            lock_cnt_reg <= lock_cnt_reg + 16'h0001;
    end

    // read latency minus one in cycles; 2.5 rounds to two plus half flag
    always_comb
    begin
        unique case (mode_reg[6:4])
            CL_CODE_2: cl_cyc = 2'h1; // see RL9
            CL_CODE_3: cl_cyc = 2'h2; // see RL9
            CL_CODE_25: cl_cyc = 2'h2; // see RL23
            default: cl_cyc = 2'h0;
        endcase
    end

    // a pipe, not a counter, so back-to-back reads each get their marker
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            rd_pipe_reg <= 2'h0;
            rd_first_reg <= 1'b0;
        end
        else
        begin
            rd_pipe_reg[0] <= rd_go && cl_cyc == 2'h2;
            rd_pipe_reg[1] <= rd_pipe_reg[0] || (rd_go && cl_cyc == 2'h1); // see RL9
            rd_first_reg <= rd_pipe_reg[1];
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
            is_read_reg <= 1'b0;
        else if (col_go)
            is_read_reg <= i_cmd_read;
    end

    // reads and writes share the single programmed length
    assign bif.start = col_go; // see RL8
    assign bif.col = i_cmd_addr[9:0] & COL_MASK; // see RL7
    assign bif.bl_code = mode_reg[2:0];
    assign bif.ilv = mode_reg[MR_BT_BIT]; // see RL6

    ddb_burst_seq u_seq (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .bus(bif.seq)
    );

    // avalon slave: one wait cycle on every access
    assign bus_req = i_avs_read || i_avs_write;
    assign bus_wr = i_avs_write && ack_reg;
    assign o_avs_waitrequest = bus_req && !ack_reg;

    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
            ack_reg <= 1'b0;
        else
            ack_reg <= bus_req && !ack_reg;
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
            ctrl_en_reg <= CTRL_EN_RST;
        else if (bus_wr && i_avs_address == REG_CTRL && i_avs_byteenable[0])
            ctrl_en_reg <= i_avs_writedata[0];
    end

    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[ST_DLL_EN] = o_dll_enable;
        status_word[ST_DLL_RDY] = o_dll_ready;
        status_word[ST_DS] = ext_reg[EMR_DS_BIT];
        status_word[ST_RSVD] = rsvd_reg;
        status_word[ST_BUSY] = bif.col_valid && !bif.last;
    end

    always_comb
    begin
        unique case (i_avs_address)
            REG_CTRL: rd_mux = {31'h0000_0000, ctrl_en_reg};
            REG_MODE: rd_mux = {25'h000_0000, mode_reg};
            REG_EXT: rd_mux = {30'h0000_0000, ext_reg};
            REG_STATUS: rd_mux = status_word;
            REG_BURST: rd_mux = {15'h0000, is_read_reg, 6'h00, bif.col_out};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
            rdata_reg <= 32'h0000_0000;
        else if (i_avs_read && !ack_reg)
            rdata_reg <= rd_mux;
    end

    assign o_avs_readdata = rdata_reg;
    assign o_col_addr = bif.col_out;
    assign o_col_valid = bif.col_valid;
    assign o_col_last = bif.last;
    assign o_col_is_read = is_read_reg;
    assign o_rd_first_valid = rd_first_reg;
    assign o_rd_half_cycle = mode_reg[6:4] == CL_CODE_25;
    assign o_dll_enable = !ext_reg[EMR_DLLDIS_BIT];
    assign o_dll_reset = dll_rst_reg;
    assign o_dll_ready = o_dll_enable && lock_cnt_reg >= 16'(DLL_LOCK_CYCLES);
    assign o_output_drive_select = ext_reg[EMR_DS_BIT]; // see RL19

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    mode_load_a: assert property (mr_normal |=> mode_reg == $past(i_cmd_addr[6:0])) // see RL10
        else $error("normal mode set did not load the mode register");
    dll_reset_a: assert property (mr_dllrst |=> o_dll_reset ##1 !o_dll_reset) // see RL11
        else $error("dll reset pulse missing or stretched");
    mode_hold_a: assert property (!(mr_normal || mr_dllrst) |=> $stable(mode_reg)) // see RL20
        else $error("mode register changed without a load");
    rsvd_flag_a: assert property ((mrs_go && i_cmd_ba == BA_MR // see RL13
        && i_cmd_addr[MR_TM_BIT]) |=> rsvd_reg && $stable(mode_reg))
        else $error("reserved mode code was not refused");
    emr_load_a: assert property ((emr_go && !i_sr_exit) |=> // see RL14
        ext_reg == $past(i_cmd_addr[1:0]))
        else $error("extended mode register did not load");
    ext_hold_a: assert property (!(emr_go || i_sr_exit) |=> $stable(ext_reg)) // see RL14
        else $error("extended mode register changed without a load");
    sr_exit_dll_a: assert property (i_sr_exit |=> o_dll_enable) // see RL17
        else $error("dll not enabled after self refresh exit");
    lock_clear_a: assert property (mr_dllrst |=> !o_dll_ready) // see RL18
        else $error("dll ready did not drop on a dll reset");
    cl2_first_a: assert property ((rd_go && mode_reg[6:4] == CL_CODE_2) // see RL9
        |-> ##2 o_rd_first_valid)
        else $error("latency two first data marker misplaced");
    cl3_first_a: assert property ((rd_go && mode_reg[6:4] == CL_CODE_3 // see RL9
        && !rd_pipe_reg[0])
        |-> ##1 !o_rd_first_valid ##1 !o_rd_first_valid ##1 o_rd_first_valid)
        else $error("latency three first data marker misplaced");
    cl25_first_a: assert property ((rd_go && mode_reg[6:4] == CL_CODE_25 // see RL23
        && !rd_pipe_reg[0]) |-> ##3 o_rd_first_valid)
        else $error("latency two and a half first data marker misplaced");
    col_start_a: assert property (col_go |=> // see RL8
        o_col_valid && o_col_addr == $past(bif.col))
        else $error("burst did not start on the commanded column");
    col_mask_a: assert property (o_col_valid |-> // see RL7
        (o_col_addr & ~COL_MASK) == 10'h000)
        else $error("burst column uses a bit outside the column field");
    drive_sel_a: assert property ((emr_go && i_cmd_addr[EMR_DS_BIT]) // see RL19
        |=> o_output_drive_select)
        else $error("reduced drive strength not selected");
    drive_full_a: assert property ((emr_go && !i_cmd_addr[EMR_DS_BIT]) // see RL19
        |=> !o_output_drive_select)
        else $error("full drive strength not restored");
    bus_wait_a: assert property ((bus_req && o_avs_waitrequest) |=> !o_avs_waitrequest)
        else $error("waitrequest held longer than one cycle");
endmodule // ddb_mode_burst

// ### ddb_ctl_model.sv
// controller model issuing mode register, column and self refresh exit commands
module ddb_ctl_model
    import ddb_pkg::*;
(
    input wire logic i_clk,
    output logic o_mrs,
    output logic o_rd,
    output logic o_wr,
    output logic [1:0] o_ba,
    output logic [ADDR_W-1:0] o_addr,
    output logic o_sr_exit
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        o_mrs = 1'b0;
        o_rd = 1'b0;
        o_wr = 1'b0;
        o_ba = 2'h3;
        o_addr = 13'h1FFF;
        o_sr_exit = 1'b0;
    end
    task automatic issue(input logic m, input logic r, input logic [1:0] ba, input logic [12:0] a);
        begin
            @(posedge i_clk);
            o_mrs <= m;
            o_rd <= r;
            o_wr <= !m && !r;
            o_ba <= ba;
            o_addr <= a;
            @(posedge i_clk);
            o_mrs <= 1'b0;
            o_rd <= 1'b0;
            o_wr <= 1'b0;
            // idle address lines must not look like a held value
            o_ba <= ~ba;
            o_addr <= ~a;
        end
    endtask
    // reserved codes go out only when the bench probes a refusal on purpose
    task automatic mrs(input logic [1:0] ba, input logic [12:0] a);
        begin
            repeat (2) @(posedge i_clk);
            issue(1'b1, 1'b0, ba, a);
        end
    endtask
    task automatic col(input logic r, input logic [9:0] c);
        begin
            issue(1'b0, r, 2'h0, {3'h0, c});
        end
    endtask
    task automatic sr_pulse();
        begin
            @(posedge i_clk);
            o_sr_exit <= 1'b1;
            @(posedge i_clk);
            o_sr_exit <= 1'b0;
        end
    endtask
endmodule // ddb_ctl_model

// ### testbench.sv
// self-checking bench for the mode register and burst order block
module testbench;
    import ddb_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LOCK = 8;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [2:0] adr = 3'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdat;
    logic wait_r;
    logic mrs, crd, cwr, srx;
    logic [1:0] ba;
    logic [12:0] addr;
    logic [9:0] col;
    logic cval, clast, cisrd, first, half, dll_en, dll_rst, dll_rdy, drive;
    logic [31:0] q;
    int err_total = 0;
    int tests_run = 0;
    ddb_mode_burst #(.ORG(ORG_X8), .DLL_LOCK_CYCLES(LOCK)) dut (
        .i_clk(clk), .i_nrst(nrst), .i_avs_address(adr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hF),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wait_r), .i_cmd_mrs(mrs),
        .i_cmd_read(crd), .i_cmd_write(cwr), .i_cmd_ba(ba), .i_cmd_addr(addr),
        .i_sr_exit(srx), .o_col_addr(col), .o_col_valid(cval), .o_col_last(clast),
        .o_col_is_read(cisrd), .o_rd_first_valid(first), .o_rd_half_cycle(half),
        .o_dll_enable(dll_en), .o_dll_reset(dll_rst), .o_dll_ready(dll_rdy),
        .o_output_drive_select(drive));
    ddb_ctl_model ctl (.i_clk(clk), .o_mrs(mrs), .o_rd(crd), .o_wr(cwr), .o_ba(ba),
        .o_addr(addr), .o_sr_exit(srx));
    initial
    begin
        forever #10 clk = ~clk;
    end
    task automatic stop_test();
        begin
            $display("mismatches %0d, comparisons %0d", err_total, tests_run);
            if (err_total == 0 && tests_run > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        begin
            tests_run++;
            if (got !== exp)
            begin
                err_total++;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // request held until waitrequest is seen low before an edge
    task automatic av(input logic w, input logic [2:0] a, input logic [31:0] d);
        int n;
        begin
            n = 0;
            @(posedge clk);
            rd <= !w;
            wr <= w;
            adr <= a;
            wd <= d;
            #1;
            while (wait_r !== 1'b0 && n < 50)
            begin
                @(posedge clk);
                #1;
                n++;
            end
            if (n >= 50)
            begin
                err_total++;
                $display("wrong value at %0t: bus answer missing", $time);
            end
            q = rdat;
            @(posedge clk);
            rd <= 1'b0;
            wr <= 1'b0;
        end
    endtask
    task automatic rd_chk(input logic [2:0] a, input logic [31:0] e);
        begin
            av(1'b0, a, 32'h0);
            chk(q, e);
        end
    endtask
    task automatic dll_cycle();
        begin
            ctl.mrs(BA_MR, 13'h122);
            #1;
            chk(dll_rst, 1'b1);
            chk(dll_rdy, 1'b0);
            @(posedge clk);
            #1;
            chk(dll_rst, 1'b0);
            ctl.mrs(BA_MR, 13'h022);
            repeat (LOCK) @(posedge clk);
            #1;
            chk(dll_rdy, 1'b1);
        end
    endtask
    task automatic run_case(input int j, input logic r, input int k);
        logic [2:0] blc, cl;
        logic [9:0] c, e;
        int bl, lat, off;
        logic il;
        begin
            blc = (j % 3 == 0) ? BL_CODE_2 : (j % 3 == 1) ? BL_CODE_4 : BL_CODE_8;
            bl = 2 << (j % 3);
            il = (j >= 3);
            cl = ((j + k) % 3 == 0) ? CL_CODE_2 : ((j + k) % 3 == 1) ? CL_CODE_3 : CL_CODE_25;
            lat = (cl == CL_CODE_2) ? 1 : 2;
            off = k ? bl - 1 : 1;
            // top column bit nine set so a dropped bit shows
            c = 10'h3F0 | 10'(off);
            ctl.mrs(BA_MR, {6'h00, cl, il, blc});
            #1;
            chk(half, cl == CL_CODE_25);
            ctl.col(r, c);
            for (int i = 0; i < 10; i++)
            begin
                #1;
                e = il ? 10'(off ^ i) : 10'((off + i) % bl);
                chk(cval, i < bl);
                if (i < bl)
                begin
                    chk(col, (c & ~10'(bl - 1)) | e);
                    chk(clast, i == bl - 1);
                end
                chk(first, r && i == lat);
                if (i == 0)
                    chk(cisrd, r);
                @(posedge clk);
            end
        end
    endtask
    initial
    begin
        #400000;
        err_total++;
        stop_test();
    end
    initial
    begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        rd_chk(REG_CTRL, 32'h1);
        rd_chk(REG_STATUS, 32'h1);
        rd_chk(3'h5, 32'h0);
        dll_cycle();
        rd_chk(REG_MODE, 32'h22);
        for (int j = 0; j < 6; j++)
            for (int r = 0; r < 2; r++)
                for (int k = 0; k < 2; k++)
                    run_case(j, r[0], k);
        // a column read is refused while the enable is off
        av(1'b1, REG_CTRL, 32'h0);
        ctl.col(1'b1, 10'h000);
        #1;
        chk(cval, 1'b0);
        av(1'b1, REG_CTRL, 32'h1);
        ctl.mrs(BA_EMR, 13'h002);
        #1;
        chk(drive, 1'b1);
        chk(dll_en, 1'b1);
        rd_chk(REG_EXT, 32'h2);
        ctl.mrs(BA_EMR, 13'h003);
        #1;
        chk(dll_en, 1'b0);
        ctl.sr_pulse();
        #1;
        chk(dll_en, 1'b1);
        chk(drive, 1'b1);
        dll_cycle();
        ctl.mrs(BA_MR, {6'h00, CL_CODE_2, 1'b0, BL_CODE_4});
        ctl.mrs(BA_MR, 13'h0A3);
        rd_chk(REG_MODE, 32'h22);
        rd_chk(REG_STATUS, 32'h0F);
        av(1'b1, REG_STATUS, 32'h8);
        ctl.mrs(BA_MR, 13'h223);
        rd_chk(REG_MODE, 32'h22);
        rd_chk(REG_STATUS, 32'h0F);
        av(1'b1, REG_STATUS, 32'h8);
        rd_chk(REG_STATUS, 32'h07);
        ctl.mrs(BA_EMR, 13'h000);
        #1;
        chk(drive, 1'b0);
        stop_test();
    end
endmodule // testbench
